/* File: rtl/dpr_map.svh */
/*
 timing constants and widths of the dual-port memory host controller.
 assumes a 100 MHz clock; included by bare name.
*/
`ifndef DPR_MAP_SVH
`define DPR_MAP_SVH
`define DPR_CLK_PERIOD_NS 10
`define DPR_ADDR_W 12
`define DPR_DATA_W 8
`define DPR_DEPTH 4096
// read: longest access, ns
`define DPR_T_ACCESS_NS 70
// write pulse, ns
`define DPR_T_WRITE_PULSE_NS 60
// driver turn-off to high-z plus data setup, ns
`define DPR_T_TURNOFF_NS 30
`define DPR_T_SETUP_NS 30
// gap with strobes high between accesses, ns
`define DPR_T_RECOVER_NS 10
`define DPR_CYC(ns) (((ns) + `DPR_CLK_PERIOD_NS - 1) / `DPR_CLK_PERIOD_NS)
`endif

/* File: rtl/dpr_pkg.sv */
/*
 types of the dual-port memory host controller.
 assumes dpr_map.svh is on the include path.
*/
`include "dpr_map.svh"
package dpr_pkg;
    typedef enum logic [2:0] {
        DPR_IDLE,
        DPR_SETUP,
        DPR_READ,
        DPR_WRITE,
        DPR_RECOVER
    } dpr_state_t;
    typedef logic [`DPR_ADDR_W-1:0] dpr_addr_t;
    typedef logic [`DPR_DATA_W-1:0] dpr_data_t;
endpackage

/* File: rtl/dpr_port_seq.sv */
/*
 one host-side port sequencer for a static dual-port memory port.
 assumes pins synchronous to clock and the memory answers within the read time.
*/
`timescale 1ns/1ps
`include "dpr_map.svh"
module dpr_port_seq #(
    parameter int READ_CYC = `DPR_CYC(`DPR_T_ACCESS_NS),
    parameter int WRITE_CYC = `DPR_CYC(`DPR_T_WRITE_PULSE_NS),
    parameter int TURN_CYC = `DPR_CYC(`DPR_T_TURNOFF_NS + `DPR_T_SETUP_NS),
    parameter int REC_CYC = `DPR_CYC(`DPR_T_RECOVER_NS)
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_oe_low,
    input wire dpr_pkg::dpr_addr_t req_addr,
    input wire dpr_pkg::dpr_data_t req_wdata,
    output logic rsp_valid,
    output dpr_pkg::dpr_data_t rsp_rdata,
    output logic sel_n,
    output logic rw_n,
    output logic oe_n,
    output dpr_pkg::dpr_addr_t port_address_bus,
    output dpr_pkg::dpr_data_t port_data_bus_out,
    output logic port_data_bus_oe,
    input wire dpr_pkg::dpr_data_t port_data_bus_in
);
    import dpr_pkg::*;
    localparam int WMAX = (WRITE_CYC > TURN_CYC) ? WRITE_CYC : TURN_CYC;
    typedef struct packed {
        dpr_state_t st;
        logic [7:0] cnt;
        logic wr;
        logic oel;
        dpr_addr_t addr;
        dpr_data_t wdata;
        dpr_data_t rdata;
        logic rvalid;
        logic sel_n;
        logic rw_n;
        logic oe_n;
        logic drive;
    } dpr_seq_t;
    dpr_seq_t s_r;
    dpr_seq_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        unique case (s_r.st)
            DPR_IDLE: begin
                if (req_valid) begin
                    // address changes only with select and direction high
                    s_nxt.addr = req_addr;
                    s_nxt.wdata = req_wdata;
                    s_nxt.wr = req_write;
                    s_nxt.oel = req_oe_low;
                    s_nxt.st = DPR_SETUP;
                end
            end
            DPR_SETUP: begin
                s_nxt.sel_n = 1'b0;
                if (s_r.wr) begin
                    // direction low with select; data held off the pins first
                    s_nxt.rw_n = 1'b0;
                    s_nxt.oe_n = ~s_r.oel;
                    s_nxt.cnt = 8'(s_r.oel ? WMAX : WRITE_CYC);
                    s_nxt.st = DPR_WRITE;
                end else begin
                    // read needs select and oe both low
                    s_nxt.oe_n = 1'b0;
                    s_nxt.cnt = 8'(READ_CYC);
                    s_nxt.st = DPR_READ;
                end
            end
            DPR_READ: begin
                if (s_r.cnt == 8'h01) begin
                    s_nxt.rdata = port_data_bus_in;
                    s_nxt.rvalid = 1'b1;
                    s_nxt.sel_n = 1'b1;
                    s_nxt.oe_n = 1'b1;
                    s_nxt.cnt = 8'(REC_CYC);
                    s_nxt.st = DPR_RECOVER;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            DPR_WRITE: begin
                // drive after device drivers off when oe low
                if (s_r.cnt <= 8'(WRITE_CYC) || !s_r.oel) begin
                    s_nxt.drive = 1'b1;
                end
                if (s_r.cnt == 8'h01) begin
                    // direction, select and oe rise together, data kept one more cycle as hold
                    s_nxt.rw_n = 1'b1;
                    s_nxt.sel_n = 1'b1;
                    s_nxt.oe_n = 1'b1;
                    s_nxt.cnt = 8'(REC_CYC);
                    s_nxt.st = DPR_RECOVER;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            DPR_RECOVER: begin
                s_nxt.drive = 1'b0;
                if (s_r.cnt <= 8'h01) begin
                    s_nxt.st = DPR_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.st <= DPR_IDLE;
            s_r.sel_n <= 1'b1;
            s_r.rw_n <= 1'b1;
            s_r.oe_n <= 1'b1;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign req_ready = (s_r.st == DPR_IDLE);
    assign rsp_valid = s_r.rvalid;
    assign rsp_rdata = s_r.rdata;
    assign sel_n = s_r.sel_n;
    assign rw_n = s_r.rw_n;
    assign oe_n = s_r.oe_n;
    assign port_address_bus = s_r.addr;
    assign port_data_bus_out = s_r.wdata;
    assign port_data_bus_oe = s_r.drive;
endmodule

/* File: rtl/dpr_host.sv */
/*
 host controller driving both ports of an asynchronous 4K x 8 dual-port static memory.
 assumes one 100 MHz clock, pins sampled synchronously, and the testbench resolving
 the data wires from the enables.
*/
// Contract
// - The host keeps direction or select high whenever it changes the address.
// - The host does not drive data while the memory still drives the pins.
// - With output enable low the write pulse is the longer of pulse or turn-off plus setup.
// - Behaviour holds only for different addresses; there is no arbitration or busy flag.
// - The users keep data integrity on same-address access themselves.
`timescale 1ns/1ps
`include "dpr_map.svh"
module dpr_host #(
    parameter int READ_CYC = `DPR_CYC(`DPR_T_ACCESS_NS),
    parameter int WRITE_CYC = `DPR_CYC(`DPR_T_WRITE_PULSE_NS),
    parameter int TURN_CYC = `DPR_CYC(`DPR_T_TURNOFF_NS + `DPR_T_SETUP_NS),
    parameter int REC_CYC = `DPR_CYC(`DPR_T_RECOVER_NS)
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [1:0] req_valid,
    output logic [1:0] req_ready,
    input wire logic [1:0] req_write,
    input wire logic [1:0] req_oe_low,
    input wire dpr_pkg::dpr_addr_t [1:0] req_addr,
    input wire dpr_pkg::dpr_data_t [1:0] req_wdata,
    output logic [1:0] rsp_valid,
    output dpr_pkg::dpr_data_t [1:0] rsp_rdata,
    output logic [1:0] sel_n,
    output logic [1:0] rw_n,
    output logic [1:0] oe_n,
    output dpr_pkg::dpr_addr_t [1:0] port_address_bus,
    output dpr_pkg::dpr_data_t [1:0] port_data_bus_out,
    output logic [1:0] port_data_bus_oe,
    input wire dpr_pkg::dpr_data_t [1:0] port_data_bus_in,
    output logic same_addr_warn
);
    import dpr_pkg::*;
    typedef struct packed {
        logic warn;
    } dpr_top_t;
    dpr_top_t t_r;
    dpr_top_t t_nxt;

    // one sequencer per port, fully independent
    for (genvar p = 0; p < 2; p++) begin : g_port
        dpr_port_seq #(
            .READ_CYC(READ_CYC),
            .WRITE_CYC(WRITE_CYC),
            .TURN_CYC(TURN_CYC),
            .REC_CYC(REC_CYC)
        ) u_seq (
            .clock(clock),
            .rstn(rstn),
            .clk_en(clk_en),
            .req_valid(req_valid[p]),
            .req_ready(req_ready[p]),
            .req_write(req_write[p]),
            .req_oe_low(req_oe_low[p]),
            .req_addr(req_addr[p]),
            .req_wdata(req_wdata[p]),
            .rsp_valid(rsp_valid[p]),
            .rsp_rdata(rsp_rdata[p]),
            .sel_n(sel_n[p]),
            .rw_n(rw_n[p]),
            .oe_n(oe_n[p]),
            .port_address_bus(port_address_bus[p]),
            .port_data_bus_out(port_data_bus_out[p]),
            .port_data_bus_oe(port_data_bus_oe[p]),
            .port_data_bus_in(port_data_bus_in[p])
        );
    end

    // flag both ports selected on one address; no arbitration done
    always_comb begin
        t_nxt = t_r;
        t_nxt.warn = !sel_n[0] && !sel_n[1] && (port_address_bus[0] == port_address_bus[1]);
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            t_r <= '0;
        end else if (clk_en) begin
            t_r <= t_nxt;
        end
    end

    assign same_addr_warn = t_r.warn;
endmodule

/* File: test/dpr_host_checker.sv */
/*
 pin assertions of the dual-port memory host controller.
 assumes a bind onto dpr_host in the testbench top.
*/
`timescale 1ns/1ps
module dpr_host_checker #(
    parameter int READ_CYC = 7
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [1:0] sel_n,
    input wire logic [1:0] rw_n,
    input wire logic [1:0] oe_n,
    input wire dpr_pkg::dpr_addr_t [1:0] port_address_bus,
    input wire logic [1:0] port_data_bus_oe,
    input wire dpr_pkg::dpr_data_t [1:0] port_data_bus_in,
    input wire logic [1:0] rsp_valid,
    input wire dpr_pkg::dpr_data_t [1:0] rsp_rdata,
    input wire logic [1:0] req_ready,
    input wire logic same_addr_warn
);
    import dpr_pkg::*;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    a_addr_hold: assert property ($changed(port_address_bus[0]) |->
        sel_n[0] && $past(sel_n[0]))
        else $error("address moved while selected");
    a_no_clash: assert property (port_data_bus_oe[1] |->
        !(rw_n[1] && !sel_n[1] && !oe_n[1]))
        else $error("host drives during read");
    a_sel_dir: assert property ($fell(rw_n[0]) |-> $fell(sel_n[0]) && !port_data_bus_oe[0])
        else $error("select not with direction");
    a_pulse_len: assert property ($fell(rw_n[0]) |->
        (!rw_n[0] && !sel_n[0])[*6] ##1 (rw_n[0] && sel_n[0]))
        else $error("write pulse length");
    a_pulse_right: assert property ($fell(rw_n[1]) |->
        (!rw_n[1] && !sel_n[1])[*6] ##1 (rw_n[1] && sel_n[1]))
        else $error("right write pulse length");
    a_read_time: assert property ($fell(sel_n[0]) && rw_n[0] |-> ##READ_CYC rsp_valid[0])
        else $error("read answer late");
    a_rdata_cap: assert property (rsp_valid[1] |->
        rsp_rdata[1] == $past(port_data_bus_in[1]))
        else $error("read data not captured");
    a_idle_quiet: assert property (req_ready[0] |->
        sel_n[0] && rw_n[0] && !port_data_bus_oe[0])
        else $error("idle port not quiet");
    a_warn_set: assert property (sel_n == 2'b00
        && port_address_bus[0] == port_address_bus[1] |=> same_addr_warn)
        else $error("same address not flagged");
endmodule

/* File: test/dpr_mem_model.sv */
/*
 behavioural dual-port 4K x 8 static memory.
 assumes strobes synchronous to clock and resolved data wires.
*/
`timescale 1ns/1ps
module dpr_mem_model (
    input wire logic clock,
    input wire logic [1:0] sel_n,
    input wire logic [1:0] rw_n,
    input wire logic [1:0] oe_n,
    input wire dpr_pkg::dpr_addr_t [1:0] addr,
    input wire dpr_pkg::dpr_data_t [1:0] din,
    output dpr_pkg::dpr_data_t [1:0] dout,
    output logic [1:0] drive
);
    import dpr_pkg::*;
    dpr_data_t mem [4096];
    logic clash;
    assign clash = sel_n == 2'b00 && addr[0] == addr[1];
    always @(posedge clock) begin
        for (int p = 0; p < 2; p++) begin
            if (!sel_n[p] && !rw_n[p]) begin
                mem[addr[p]] <= clash ? 8'hXX : din[p];
            end
        end
    end
    for (genvar p = 0; p < 2; p++) begin : g_port
        assign drive[p] = !sel_n[p] && rw_n[p] && !oe_n[p];
        assign dout[p] = mem[addr[p]];
    end
endmodule

/* File: test/dpr_host_tb_top.sv */
/*
 testbench top of the dual-port memory host controller.
 assumes the memory model on the far side and the checker bound below.
*/
`timescale 1ns/1ps
module dpr_host_tb_top;
    import dpr_pkg::*;
    logic clock = 0;
    logic rstn = 0;
    logic clk_en = 1;
    logic [1:0] rv = 0, rw = 0, rol = 0;
    dpr_addr_t [1:0] ra = '0;
    dpr_data_t [1:0] rd = '0;
    logic [1:0] rdy, vld, sel_n, rw_n, oe_n, doe, mdrv;
    dpr_data_t [1:0] q, dout, din, mout;
    dpr_addr_t [1:0] abus;
    logic warn;
    logic warn_seen = 0;
    dpr_data_t flt = 8'h00;
    int failures = 0;
    int num_checks = 0;
    always #5 clock = ~clock;
    always @(posedge clock) begin
        flt <= flt + 8'h5B;
        warn_seen <= warn_seen | (rstn && warn);
    end
    for (genvar p = 0; p < 2; p++) begin : g_wire
        assign din[p] = (doe[p] && mdrv[p]) ? 8'hXX : doe[p] ? dout[p] : mdrv[p] ? mout[p] : flt;
    end
    dpr_host DUT (.clock(clock), .rstn(rstn), .clk_en(clk_en), .req_valid(rv), .req_ready(rdy),
        .req_write(rw), .req_oe_low(rol), .req_addr(ra), .req_wdata(rd), .rsp_valid(vld),
        .rsp_rdata(q), .sel_n(sel_n), .rw_n(rw_n), .oe_n(oe_n), .port_address_bus(abus),
        .port_data_bus_out(dout), .port_data_bus_oe(doe), .port_data_bus_in(din),
        .same_addr_warn(warn));
    dpr_mem_model u_mem (.clock(clock), .sel_n(sel_n), .rw_n(rw_n), .oe_n(oe_n), .addr(abus),
        .din(din), .dout(mout), .drive(mdrv));
    task automatic chk(input dpr_data_t got, input dpr_data_t exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_flag(input int p, input logic rsp);
        int n;
        n = 0;
        while ((rsp ? vld[p] : rdy[p]) !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        chk({7'h0, n < 50}, 8'h01);
    endtask
    task automatic acc(input int p, input logic w, input logic ol, input dpr_addr_t a,
        input dpr_data_t d, output dpr_data_t r);
        wait_flag(p, 1'b0);
        rv[p] = 1'b1;
        rw[p] = w;
        rol[p] = ol;
        ra[p] = a;
        rd[p] = d;
        @(negedge clock);
        rv[p] = 1'b0;
        wait_flag(p, !w);
        r = q[p];
    endtask
    task automatic t_cross;
        dpr_data_t r;
        chk({6'h0, sel_n}, 8'h03);
        acc(0, 1, 0, 12'h000, 8'hA5, r);
        acc(1, 0, 0, 12'h000, 8'h00, r);
        chk(r, 8'hA5);
        acc(1, 1, 1, 12'hFFF, 8'h3C, r);
        acc(0, 0, 0, 12'hFFF, 8'h00, r);
        chk(r, 8'h3C);
        $display("test cross done");
    endtask
    task automatic t_dual;
        dpr_data_t r0, r1;
        fork
            acc(0, 1, 0, 12'h123, 8'h11, r0);
            acc(1, 1, 1, 12'h321, 8'h22, r1);
        join
        fork
            acc(0, 0, 0, 12'h321, 8'h00, r0);
            acc(1, 0, 0, 12'h123, 8'h00, r1);
        join
        chk(r0, 8'h22);
        chk(r1, 8'h11);
        chk({7'h0, warn_seen}, 8'h00);
        fork
            acc(0, 0, 0, 12'h123, 8'h00, r0);
            acc(1, 0, 0, 12'h123, 8'h00, r1);
        join
        chk({7'h0, warn_seen}, 8'h01);
        $display("test dual done");
    endtask
    task automatic t_freeze;
        wait_flag(0, 1'b0);
        clk_en = 1'b0;
        rv[0] = 1'b1;
        rw[0] = 1'b0;
        ra[0] = 12'h321;
        repeat (4) @(negedge clock);
        chk({7'h0, sel_n[0]}, 8'h01);
        clk_en = 1'b1;
        @(negedge clock);
        rv[0] = 1'b0;
        wait_flag(0, 1'b1);
        chk(q[0], 8'h22);
        $display("test freeze done");
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #50000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(negedge clock);
        rstn = 1'b1;
        t_cross();
        t_dual();
        t_freeze();
        tally_and_finish();
    end
endmodule
bind dpr_host dpr_host_checker #(.READ_CYC(READ_CYC)) u_chk (.clock(clock), .rstn(rstn),
    .sel_n(sel_n), .rw_n(rw_n), .oe_n(oe_n), .port_address_bus(port_address_bus),
    .port_data_bus_oe(port_data_bus_oe), .port_data_bus_in(port_data_bus_in),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .req_ready(req_ready),
    .same_addr_warn(same_addr_warn));
